// file: ccs_map.svh
// Constants for the charger control sequencer
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
`define CCS_CLK_HZ 20000000
`define CCS_TICK_MS_DIV 20000
`define CCS_UNATT_MIN 15
`define CCS_UNATT_MS (`CCS_UNATT_MIN * 60 * 1000)
`define CCS_ALIVE_S 32
`define CCS_ALIVE_MS (`CCS_ALIVE_S * 1000)
`define CCS_QUAL_MS 30
`define CCS_DONE_CHECK_MS 500
`define CCS_ICHG_BASE_UV 37400
`define CCS_ICHG_STEP_UV 6800
`define CCS_END_CURRENT_CODE_STEP_A_UV 3400
`define CCS_END_CURRENT_CODE_STEP_B_UV 3300
`define CCS_FAULT_NONE 3'h0
`define CCS_FAULT_TIMER 3'h6
`define CCS_STAT_READY 2'h0
`define CCS_STAT_CHARGE 2'h1
`define CCS_STAT_DONE 2'h2
`define CCS_DEF_ICHG 3'h0
`define CCS_DEF_END_CURRENT_CODE 3'h0
`define CCS_DEF_ILIM 2'h0
`define CCS_DEF_FLOAT 6'h02
`define CCS_DEF_END_ON 1'b0
`define CCS_ILIM_100MA 10'h064
`define CCS_ILIM_500MA 10'h1f4
`define CCS_ILIM_800MA 10'h320
`define CCS_ILIM_NONE 10'h3ff
`endif

// file: ccs_pkg.sv
// Types for the charger control sequencer
package ccs_pkg;
    typedef struct packed {
        logic [2:0] charge_current_code;
        logic [2:0] end_current_code;
        logic [1:0] input_limit_code;
        logic [5:0] float_setting;
        logic end_detect_on;
        logic charger_off;
        logic high_impedance_request;
    } ccs_cfg_t;
    typedef enum logic [2:0] {
        CCS_IDLE = 3'b000,
        CCS_QUAL = 3'b001,
        CCS_CHARGE = 3'b010,
        CCS_CHECK = 3'b011,
        CCS_DONE = 3'b100
    } ccs_state_t;
endpackage

// file: ccs_ms_timer.sv
// Millisecond prescaler and stage timer
`timescale 1ns/1ps
module ccs_ms_timer #(
    parameter int DIV = 20000,
    parameter int CW = 21
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic clear_i,
    input wire logic [CW-1:0] limit_i,
    output logic expired_o
);
    // ==========================================
    // Prescaled count
    typedef struct packed {
        logic [15:0] pre;
        logic [CW-1:0] cnt;
    } ccs_tm_state_t;
    ccs_tm_state_t t_reg;
    ccs_tm_state_t t_next;
    logic tick;
    assign tick = (t_reg.pre == 16'(DIV - 1));
    always_comb begin
        t_next = t_reg;
        if (clear_i || !run_i) begin
            t_next.pre = 16'h0000;
        end else begin
            t_next.pre = tick ? 16'h0000 : t_reg.pre + 16'h0001;
        end
        if (clear_i) begin
            t_next.cnt = '0;
        end else if (run_i && tick && t_reg.cnt != limit_i) begin
            t_next.cnt = t_reg.cnt + CW'(1);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end
    assign expired_o = run_i && (t_reg.cnt == limit_i);
endmodule // ccs_ms_timer

// file: ccs_sequencer.sv
// Charger control sequencer top
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_sequencer #(
    parameter bit AUTO_START = 1'b1,
    parameter bit LATE_VARIANT = 1'b0,
    parameter int TICK_DIV = `CCS_TICK_MS_DIV,
    parameter int UNATT_MS = `CCS_UNATT_MS,
    parameter int ALIVE_MS = `CCS_ALIVE_MS,
    parameter int QUAL_MS = `CCS_QUAL_MS,
    parameter int CHECK_MS = `CCS_DONE_CHECK_MS
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic reg_write_i,
    input wire logic host_alive_kick_i,
    input wire ccs_pkg::ccs_cfg_t cfg_wr_i,
    input wire logic supply_above_min_i,
    input wire logic supply_over_i,
    input wire logic battery_weak_i,
    input wire logic battery_present_i,
    input wire logic below_recharge_i,
    input wire logic current_below_end_i,
    input wire logic host_port_select_pin_i,
    output ccs_pkg::ccs_cfg_t cfg_o,
    output logic supply_load_o,
    output logic charging_o,
    output logic [1:0] stat_code_o,
    output logic [2:0] fault_code_o,
    output logic stat_pulse_o,
    output logic unattended_run_o,
    output logic alive_run_o,
    output logic [16:0] charge_sense_uv_o,
    output logic [14:0] end_sense_uv_o,
    output logic [9:0] input_limit_ma_o
);
    // ==========================================
    // State
    typedef struct packed {
        ccs_pkg::ccs_state_t st;
        ccs_pkg::ccs_cfg_t cfg;
        logic supply_load;
        logic [1:0] stat;
        logic [2:0] fault;
        logic stat_pulse;
        logic unatt_run;
        logic alive_run;
        logic supply_seen;
        logic charging;
        logic [16:0] chg_uv;
        logic [14:0] end_uv;
        logic [9:0] lim_ma;
    } ccs_sq_state_t;
    ccs_sq_state_t s_reg;
    ccs_sq_state_t s_next;

    localparam ccs_pkg::ccs_cfg_t CFG_DEF = '{
        charge_current_code: `CCS_DEF_ICHG, end_current_code: `CCS_DEF_END_CURRENT_CODE,
        input_limit_code: `CCS_DEF_ILIM, float_setting: `CCS_DEF_FLOAT,
        end_detect_on: `CCS_DEF_END_ON, charger_off: 1'b0, high_impedance_request: 1'b0};

    // ==========================================
    // Decoders
    // Input limit decode
    function automatic logic [9:0] lim_decode(input logic [1:0] c);
        case (c)
            2'h0: lim_decode = `CCS_ILIM_100MA;
            2'h1: lim_decode = `CCS_ILIM_500MA;
            2'h2: lim_decode = `CCS_ILIM_800MA;
            default: lim_decode = `CCS_ILIM_NONE;
        endcase
    endfunction

    // ==========================================
    // Timers, one shared count module each
    localparam int CW = 21;
    logic unatt_exp;
    logic alive_exp;
    logic qual_exp;
    logic check_exp;
    logic qual_run;
    logic check_run;
    logic alive_clear;
    logic unatt_clear;
    logic [CW-1:0] qual_lim;
    logic [CW-1:0] check_lim;
    assign qual_run = (s_reg.st == ccs_pkg::CCS_QUAL) && supply_above_min_i && !supply_over_i;
    assign check_run = (s_reg.st == ccs_pkg::CCS_CHECK);
    // Kick or any write restarts host-alive count
    assign alive_clear = reg_write_i || host_alive_kick_i || !s_reg.alive_run;
    assign unatt_clear = reg_write_i || !s_reg.unatt_run;
    // Qualify/check windows each have their own counter, u_qual and u_check
    assign qual_lim = CW'(QUAL_MS);
    assign check_lim = CW'(CHECK_MS);

    ccs_ms_timer #(.DIV(TICK_DIV), .CW(CW)) u_unatt (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(s_reg.unatt_run),
        .clear_i(unatt_clear),
        .limit_i(CW'(UNATT_MS)),
        .expired_o(unatt_exp)
    );
    ccs_ms_timer #(.DIV(TICK_DIV), .CW(CW)) u_alive (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(s_reg.alive_run),
        .clear_i(alive_clear),
        .limit_i(CW'(ALIVE_MS)),
        .expired_o(alive_exp)
    );
    // Qualification window, restarts on any dropout
    ccs_ms_timer #(.DIV(TICK_DIV), .CW(CW)) u_qual (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(qual_run),
        .clear_i(!qual_run),
        .limit_i(qual_lim),
        .expired_o(qual_exp)
    );
    ccs_ms_timer #(.DIV(TICK_DIV), .CW(CW)) u_check (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(check_run),
        .clear_i(!check_run),
        .limit_i(check_lim),
        .expired_o(check_exp)
    );

    // ==========================================
    // Next state
    logic [2:0] end_idx;
    always_comb begin
        s_next = s_reg;
        s_next.stat_pulse = 1'b0;
        end_idx = 3'h0;
        if (reg_write_i) begin
            // Clearing disable or high-impedance starts a new cycle
            if ((s_reg.cfg.charger_off && !cfg_wr_i.charger_off)
                || (s_reg.cfg.high_impedance_request && !cfg_wr_i.high_impedance_request)) begin
                s_next.st = ccs_pkg::CCS_QUAL;
            end
            s_next.cfg = cfg_wr_i;
            // Write hands over to the host-alive timer
            if (s_reg.unatt_run || s_reg.alive_run) begin
                s_next.unatt_run = 1'b0;
                s_next.alive_run = 1'b1;
            end
        end
        // Load applied once supply passes threshold
        s_next.supply_load = supply_above_min_i && !supply_over_i;
        s_next.supply_seen = supply_above_min_i;
        // Power-on with weak battery on auto-start variants
        if (supply_above_min_i && !s_reg.supply_seen) begin
            if (AUTO_START && battery_weak_i) begin
                s_next.cfg = CFG_DEF;
                s_next.st = ccs_pkg::CCS_QUAL;
            end
            // Strong battery keeps settings; no auto start
        end
        case (s_reg.st)
            ccs_pkg::CCS_IDLE: begin
                s_next.unatt_run = 1'b0;
                s_next.alive_run = 1'b0;
            end
            ccs_pkg::CCS_QUAL: begin
                if (qual_exp && !s_reg.cfg.charger_off && !s_reg.cfg.high_impedance_request) begin
                    s_next.st = ccs_pkg::CCS_CHARGE;
                    s_next.stat = `CCS_STAT_CHARGE;
                    if (!s_reg.alive_run) begin
                        s_next.unatt_run = 1'b1;
                    end
                end
            end
            ccs_pkg::CCS_CHARGE: begin
                if (s_reg.cfg.end_detect_on && current_below_end_i) begin
                    s_next.st = ccs_pkg::CCS_CHECK;
                    s_next.stat = `CCS_STAT_READY;
                end
            end
            ccs_pkg::CCS_CHECK: begin
                if (check_exp) begin
                    s_next.st = (battery_present_i && supply_above_min_i) ? ccs_pkg::CCS_DONE
                                                                         : ccs_pkg::CCS_IDLE;
                    s_next.stat = (battery_present_i && supply_above_min_i) ? `CCS_STAT_DONE
                                                                           : `CCS_STAT_READY;
                end
            end
            ccs_pkg::CCS_DONE: begin
                if (below_recharge_i) begin
                    s_next.st = ccs_pkg::CCS_QUAL;
                end
            end
            default: s_next.st = ccs_pkg::CCS_IDLE;
        endcase
        // Timer expiry ends unattended charge without host; supply dropout or overvoltage only returns it to QUAL
        if (unatt_exp) begin
            s_next.st = ccs_pkg::CCS_IDLE;
            s_next.unatt_run = 1'b0;
            s_next.cfg.charger_off = 1'b1;
            s_next.fault = `CCS_FAULT_TIMER;
            s_next.stat = `CCS_STAT_READY;
        end
        // Host-alive expiry reloads defaults and resumes
        if (alive_exp && !reg_write_i && !host_alive_kick_i) begin
            s_next.cfg = CFG_DEF;
            s_next.alive_run = 1'b0;
            s_next.unatt_run = 1'b0;
            s_next.st = ccs_pkg::CCS_QUAL;
            s_next.fault = `CCS_FAULT_TIMER;
            s_next.stat_pulse = 1'b1;
        end
        if (!supply_above_min_i || supply_over_i) begin
            if (s_reg.st != ccs_pkg::CCS_IDLE) begin
                s_next.st = ccs_pkg::CCS_QUAL;
            end
        end
        // Registered so the output needs no state decode
        s_next.charging = (s_next.st == ccs_pkg::CCS_CHARGE);
        s_next.chg_uv = 17'(`CCS_ICHG_BASE_UV + `CCS_ICHG_STEP_UV * int'(s_next.cfg.charge_current_code));
        end_idx = s_next.cfg.end_current_code;
        s_next.end_uv = LATE_VARIANT ? 15'(`CCS_END_CURRENT_CODE_STEP_B_UV * (int'(end_idx) + 1))
                                     : 15'(`CCS_END_CURRENT_CODE_STEP_A_UV * (int'(end_idx) + 1));
        // Pin sets limit while unattended on auto-start variants
        if (AUTO_START && s_next.unatt_run) begin
            s_next.lim_ma = host_port_select_pin_i ? `CCS_ILIM_500MA : `CCS_ILIM_100MA;
        end else begin
            s_next.lim_ma = lim_decode(s_next.cfg.input_limit_code);
        end
    end

    // ==========================================
    // Register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_reg <= '{
                st: ccs_pkg::CCS_IDLE,
                cfg: CFG_DEF,
                supply_load: 1'b0,
                stat: `CCS_STAT_READY,
                fault: `CCS_FAULT_NONE,
                stat_pulse: 1'b0,
                unatt_run: 1'b0,
                alive_run: 1'b0,
                supply_seen: 1'b0,
                charging: 1'b0,
                chg_uv: 17'(`CCS_ICHG_BASE_UV),
                end_uv: LATE_VARIANT ? 15'(`CCS_END_CURRENT_CODE_STEP_B_UV) : 15'(`CCS_END_CURRENT_CODE_STEP_A_UV),
                lim_ma: `CCS_ILIM_100MA
            };
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg_o = s_reg.cfg;
    assign supply_load_o = s_reg.supply_load;
    assign charging_o = s_reg.charging;
    assign stat_code_o = s_reg.stat;
    assign fault_code_o = s_reg.fault;
    assign stat_pulse_o = s_reg.stat_pulse;
    assign unattended_run_o = s_reg.unatt_run;
    assign alive_run_o = s_reg.alive_run;
    assign charge_sense_uv_o = s_reg.chg_uv;
    assign end_sense_uv_o = s_reg.end_uv;
    assign input_limit_ma_o = s_reg.lim_ma;
endmodule // ccs_sequencer

// file: ccs_sequencer_asserts.sv
// Port-level checks for the charger control sequencer
`timescale 1ns/1ps
module ccs_seq_asserts #(
    parameter bit AUTO_START = 1'b1,
    parameter bit LATE_VARIANT = 1'b0,
    parameter int TICK_DIV = 4,
    parameter int QUAL_MS = 3
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic reg_write_i,
    input wire ccs_pkg::ccs_cfg_t cfg_wr_i,
    input wire logic supply_above_min_i,
    input wire logic supply_over_i,
    input wire logic current_below_end_i,
    input wire logic host_port_select_pin_i,
    input wire ccs_pkg::ccs_cfg_t cfg_o,
    input wire logic charging_o,
    input wire logic [1:0] stat_code_o,
    input wire logic [2:0] fault_code_o,
    input wire logic stat_pulse_o,
    input wire logic unattended_run_o,
    input wire logic alive_run_o,
    input wire logic [16:0] charge_sense_uv_o,
    input wire logic [14:0] end_sense_uv_o,
    input wire logic [9:0] input_limit_ma_o
);
    // Prescaler restarts with the qualify window; still allow one tick short
    localparam int QUAL_MIN = (QUAL_MS - 1) * TICK_DIV;
    logic [16:0] exp_chg;
    logic [14:0] exp_end;
    logic [9:0] exp_lim;
    logic [15:0] qual_cnt;
    // ========
    // Expected decodes
    always_comb begin
        exp_chg = 17'h09218 + 17'h01a90 * cfg_o.charge_current_code;
        exp_end = (LATE_VARIANT ? 15'h0ce4 : 15'h0d48) * (cfg_o.end_current_code + 15'h1);
        case (cfg_o.input_limit_code)
            2'h0: exp_lim = 10'h064;
            2'h1: exp_lim = 10'h1f4;
            2'h2: exp_lim = 10'h320;
            default: exp_lim = 10'h3ff;
        endcase
        if (AUTO_START && unattended_run_o)
            exp_lim = host_port_select_pin_i ? 10'h1f4 : 10'h064;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !supply_above_min_i || supply_over_i)
            qual_cnt <= 16'h0000;
        else if (qual_cnt != 16'hffff)
            qual_cnt <= qual_cnt + 16'h0001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_cfg_still;
        $stable(cfg_o) [*2];
    endsequence
    sequence s_stopped_ready;
        !charging_o && stat_code_o == 2'h0;
    endsequence
    chk_chg_decode: assert property (s_cfg_still |-> charge_sense_uv_o == exp_chg)
        else $error("bad charge sense");
    chk_end_decode: assert property (s_cfg_still |-> end_sense_uv_o == exp_end)
        else $error("bad end sense");
    chk_limit_pick: assert property ($stable(exp_lim) [*2] |-> input_limit_ma_o == exp_lim)
        else $error("bad input limit");
    chk_end_gated: assert property ($changed(stat_code_o) && stat_code_o == 2'h2 |-> cfg_o.end_detect_on)
        else $error("done without end detect");
    chk_end_stops: assert property (charging_o && cfg_o.end_detect_on && current_below_end_i |-> ##[1:3] s_stopped_ready)
        else $error("no stop on low current");
    chk_alive_expiry: assert property (stat_pulse_o |-> fault_code_o == 3'h6 && !charging_o && cfg_o.float_setting == 6'h02 ##1 !stat_pulse_o)
        else $error("bad host-alive expiry");
    chk_unatt_fault: assert property ($rose(cfg_o.charger_off) && !$past(reg_write_i) && !$past(reg_write_i, 2) |-> fault_code_o == 3'h6 && !charging_o)
        else $error("bad unattended expiry");
    chk_write_swap: assert property (reg_write_i && unattended_run_o && !cfg_wr_i.charger_off && !cfg_wr_i.high_impedance_request |=> alive_run_o && !unattended_run_o)
        else $error("write did not swap timers");
    chk_one_timer: assert property (charging_o |-> unattended_run_o != alive_run_o)
        else $error("timer count wrong");
    chk_qual_first: assert property ($rose(charging_o) |-> qual_cnt >= QUAL_MIN)
        else $error("charge before qualify");
endmodule // ccs_seq_asserts
bind ccs_sequencer ccs_seq_asserts #(.AUTO_START(AUTO_START), .LATE_VARIANT(LATE_VARIANT), .TICK_DIV(TICK_DIV),
    .QUAL_MS(QUAL_MS)) u_chk (.clk_i, .rst_b_i, .reg_write_i, .cfg_wr_i, .supply_above_min_i, .supply_over_i,
    .current_below_end_i, .host_port_select_pin_i, .cfg_o, .charging_o, .stat_code_o, .fault_code_o, .stat_pulse_o,
    .unattended_run_o, .alive_run_o, .charge_sense_uv_o, .end_sense_uv_o, .input_limit_ma_o);

// file: ccs_host_model.sv
// Host processor model: configuration writes and host-alive kicks
`timescale 1ns/1ps
module ccs_host_model #(
    parameter int KICK_GAP = 40
) (
    input wire logic clk_i,
    output ccs_pkg::ccs_cfg_t cfg_wr_o,
    output logic reg_write_o,
    output logic host_alive_kick_o
);
    logic keep_alive = 1'b0;
    int gap_cnt = 0;
    // ========
    // Host side
    initial begin
        cfg_wr_o = '0;
        reg_write_o = 1'b0;
    end
    task automatic write_cfg(input ccs_pkg::ccs_cfg_t cfg);
        @(posedge clk_i);
        #1;
        cfg_wr_o = cfg;
        reg_write_o = 1'b1;
        @(posedge clk_i);
        #1;
        reg_write_o = 1'b0;
        // Released data must not look valid
        cfg_wr_o = ~cfg;
    endtask
    always @(posedge clk_i) begin
        gap_cnt <= (gap_cnt >= KICK_GAP) ? 0 : gap_cnt + 1;
        host_alive_kick_o <= #1 keep_alive && gap_cnt >= KICK_GAP;
    end
endmodule // ccs_host_model

// file: ccs_sequencer_tb_top.sv
// Self-checking testbench for the charger control sequencer
`timescale 1ns/1ps
module ccs_sequencer_tb_top;
    // Shortened timers keep the run under a thousand cycles
    localparam int TD = 4;
    localparam int UN = 40;
    localparam int AL = 20;
    localparam int QM = 3;
    localparam int CK = 5;
    logic clk_i, rst_b_i, supply_above_min_i, supply_over_i, battery_weak_i, battery_present_i;
    logic below_recharge_i, current_below_end_i, host_port_select_pin_i, reg_write_i, host_alive_kick_i;
    logic supply_load_o, charging_o, stat_pulse_o, unattended_run_o, alive_run_o;
    logic [1:0] stat_code_o;
    logic [2:0] fault_code_o;
    logic [16:0] charge_sense_uv_o;
    logic [14:0] end_sense_uv_o;
    logic [9:0] input_limit_ma_o;
    ccs_pkg::ccs_cfg_t cfg_wr_i, cfg_o, def, c;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    ccs_sequencer #(.TICK_DIV(TD), .UNATT_MS(UN), .ALIVE_MS(AL), .QUAL_MS(QM), .CHECK_MS(CK)) uut (.clk_i,
        .rst_b_i, .reg_write_i, .host_alive_kick_i, .cfg_wr_i, .supply_above_min_i, .supply_over_i, .battery_weak_i,
        .battery_present_i, .below_recharge_i, .current_below_end_i, .host_port_select_pin_i, .cfg_o, .supply_load_o,
        .charging_o, .stat_code_o, .fault_code_o, .stat_pulse_o, .unattended_run_o, .alive_run_o, .charge_sense_uv_o,
        .end_sense_uv_o, .input_limit_ma_o);
    ccs_host_model #(.KICK_GAP(10 * TD)) host (.clk_i, .cfg_wr_o(cfg_wr_i), .reg_write_o(reg_write_i),
        .host_alive_kick_o(host_alive_kick_i));
    // ========
    // Helpers
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [9:0] lim_of(input logic [1:0] code);
        case (code)
            2'h0: return 10'h064;
            2'h1: return 10'h1f4;
            2'h2: return 10'h320;
            default: return 10'h3ff;
        endcase
    endfunction
    function automatic logic probe(input int k);
        case (k)
            0: return charging_o === 1'b1;
            1: return charging_o === 1'b0;
            2: return stat_code_o === 2'h2;
            3: return stat_pulse_o === 1'b1;
            default: return cfg_o.charger_off === 1'b1;
        endcase
    endfunction
    task automatic wait_on(input int k, input int lim, output int cnt);
        for (cnt = 0; cnt < lim && !probe(k); cnt++)
            cyc(1);
    endtask
    // Whole sequence needs about 700 cycles; the limit here is 20000 cycles
    initial begin
        #(50 * 20000);
        miscompares++;
        results();
    end
    // ========
    // Scenarios
    initial begin
        void'($urandom(32'hacd1));
        {supply_above_min_i, supply_over_i, below_recharge_i, current_below_end_i, host_port_select_pin_i} = 5'h00;
        {battery_weak_i, battery_present_i} = 2'h3;
        def = '0;
        def.float_setting = 6'h02;
        rst_b_i = 1'b0;
        cyc(2);
        rst_b_i = 1'b1;
        cyc(1);
        check({cfg_o, stat_code_o, fault_code_o, charging_o}, {def, 6'h00});
        check({charge_sense_uv_o, end_sense_uv_o, input_limit_ma_o}, {17'h09218, 15'h0d48, 10'h064});
        host_port_select_pin_i = 1'($urandom_range(1, 0));
        supply_above_min_i = 1'b1;
        wait_on(0, 50 * TD, n);
        check(charging_o, 1'b1);
        check(n >= (QM - 1) * TD, 1'b1);
        check({supply_load_o, stat_code_o, unattended_run_o, alive_run_o}, 5'h16);
        check(cfg_o, def);
        check(input_limit_ma_o, host_port_select_pin_i ? 10'h1f4 : 10'h064);
        host_port_select_pin_i = ~host_port_select_pin_i;
        cyc(3);
        check(input_limit_ma_o, host_port_select_pin_i ? 10'h1f4 : 10'h064);
        host.keep_alive = 1'b1;
        for (int i = 0; i < 8; i++) begin
            c = 17'($urandom);
            c.charge_current_code = 3'(i);
            c.end_current_code = 3'(7 - i);
            c.input_limit_code = 2'(i);
            {c.end_detect_on, c.charger_off, c.high_impedance_request} = 3'h0;
            host.write_cfg(c);
            cyc(3);
            check({cfg_o, unattended_run_o, alive_run_o}, {c, 2'h1});
            check(charge_sense_uv_o, 17'h09218 + 17'h01a90 * 17'(i));
            check(end_sense_uv_o, 15'h0d48 * 15'(8 - i));
            check(input_limit_ma_o, lim_of(c.input_limit_code));
        end
        cyc(3 * AL * TD);
        check({fault_code_o, alive_run_o, stat_pulse_o, cfg_o}, {5'h02, c});
        current_below_end_i = 1'b1;
        cyc(10 * TD);
        check(charging_o, 1'b1);
        c.end_detect_on = 1'b1;
        host.write_cfg(c);
        wait_on(1, 8, n);
        check({charging_o, stat_code_o}, 3'h0);
        wait_on(2, 3 * CK * TD, n);
        check({stat_code_o, n >= (CK - 1) * TD}, 3'h5);
        current_below_end_i = 1'b0;
        below_recharge_i = 1'b1;
        wait_on(0, 20 * TD, n);
        check({charging_o, n >= (QM - 1) * TD}, 2'h3);
        below_recharge_i = 1'b0;
        host.keep_alive = 1'b0;
        wait_on(3, 3 * AL * TD, n);
        check({stat_pulse_o, fault_code_o, cfg_o}, {4'he, def});
        cyc(1);
        check(stat_pulse_o, 1'b0);
        wait_on(0, 20 * TD, n);
        check({charging_o, unattended_run_o, alive_run_o}, 3'h6);
        wait_on(4, 2 * UN * TD, n);
        check({cfg_o.charger_off, n >= (UN - 1) * TD}, 2'h3);
        check({charging_o, fault_code_o}, 4'h6);
        host.write_cfg(def);
        wait_on(0, 20 * TD, n);
        check(charging_o, 1'b1);
        host.write_cfg(c);
        supply_over_i = 1'b1;
        battery_weak_i = 1'b0;
        cyc(2);
        check({charging_o, supply_load_o}, 2'h0);
        supply_over_i = 1'b0;
        supply_above_min_i = 1'b0;
        cyc(2);
        supply_above_min_i = 1'b1;
        wait_on(0, 20 * TD, n);
        check({charging_o, unattended_run_o, alive_run_o, cfg_o}, {3'h5, c});
        check(n >= (QM - 1) * TD, 1'b1);
        results();
    end
endmodule // ccs_sequencer_tb_top
